// ==== rtl/irq_ep_pkg.sv ====
package irq_ep_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] EP_ENABLES_OFFSET = 12'h098;
  localparam logic [11:0] EVT_STATUS_OFFSET = 12'h09C;
  localparam logic [11:0] EVT_MASK_OFFSET   = 12'h0A0;
  localparam logic [11:0] SOURCE_OFFSET     = 12'h0A4;
  localparam logic [11:0] BUS_STATUS_OFFSET = 12'h0A8;

  localparam logic [31:0] EP_ENABLES_RESET  = 32'h0000_0000;
  localparam logic [31:0] EP_ENABLES_WMASK  = 32'h97FF_FFFF;
  localparam logic [31:0] BUS_STATUS_RESET  = 32'h0000_0000;
  localparam logic [31:0] BUS_CHANGE_MASK   = 32'h0000_FFFF;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ALWAYS_ON_BIT       = 31;
  localparam int OTP_DONE_BIT        = 28;
  localparam int TX_LP_ENTRY_BIT     = 26;
  localparam int TX_LP_EXIT_BIT      = 25;
  localparam int RX_LP_BIT           = 24;
  localparam int MAC_RST_TO_BIT      = 23;
  localparam int RX_FIFO_OVF_BIT     = 22;
  localparam int TX_ERR_BIT          = 21;
  localparam int BUS_STS_BIT         = 20;
  localparam int TX_DIS_BIT          = 19;
  localparam int RX_DIS_BIT          = 18;
  localparam int XCVR_BIT            = 17;
  localparam int DATA_PORT_BIT       = 16;
  localparam int MAC_ERR_BIT         = 15;
  localparam int TX_FIFO_UNDER_BIT   = 14;
  localparam int TX_FIFO_OVER_BIT    = 13;
  localparam int BULKIN_PEND_BIT     = 12;
  localparam int PIN_COUNT           = 12;

  // Interrupt status bits for software
  localparam int IRQ_SENT_BIT        = 0;
  localparam int IRQ_EVENT_BIT       = 1;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        otp_done;
    logic        tx_lp_entry;
    logic        tx_lp_exit;
    logic        rx_lp;
    logic        mac_rst_to;
    logic        rx_fifo_ovf;
    logic        tx_err;
    logic        tx_dis;
    logic        rx_dis;
    logic        xcvr;
    logic        data_port;
    logic        mac_err;
    logic        tx_fifo_under;
    logic        tx_fifo_over;
    logic        bulkin_pend;
    logic [11:0] pins;
  } event_t;

  typedef struct packed {
    logic        poll;
    logic        busy;
  } ep_req_t;

endpackage : irq_ep_pkg

// ==== rtl/event_map.sv ====
`timescale 1ns/100ps
module event_map
  import irq_ep_pkg::*;
(
  input  event_t       events,
  input  wire logic    bus_change,
  output logic [31:0]  source_word
);

  // ---------------------------------------------------------------
  // Place each event at its enable position
  // ---------------------------------------------------------------
  always_comb begin
    source_word                    = 32'h0000_0000;
    source_word[OTP_DONE_BIT]      = events.otp_done;
    source_word[TX_LP_ENTRY_BIT]   = events.tx_lp_entry;
    source_word[TX_LP_EXIT_BIT]    = events.tx_lp_exit;
    source_word[RX_LP_BIT]         = events.rx_lp;
    source_word[MAC_RST_TO_BIT]    = events.mac_rst_to;
    source_word[RX_FIFO_OVF_BIT]   = events.rx_fifo_ovf;
    source_word[TX_ERR_BIT]        = events.tx_err;
    source_word[BUS_STS_BIT]       = bus_change;
    source_word[TX_DIS_BIT]        = events.tx_dis;
    source_word[RX_DIS_BIT]        = events.rx_dis;
    source_word[XCVR_BIT]          = events.xcvr;
    source_word[DATA_PORT_BIT]     = events.data_port;
    source_word[MAC_ERR_BIT]       = events.mac_err;
    source_word[TX_FIFO_UNDER_BIT] = events.tx_fifo_under;
    source_word[TX_FIFO_OVER_BIT]  = events.tx_fifo_over;
    source_word[BULKIN_PEND_BIT]   = events.bulkin_pend;
    source_word[PIN_COUNT-1:0]     = events.pins;
  end

endmodule : event_map

// ==== rtl/usb_interrupt_endpoint_event_gate.sv ====
// What this block does
// - Always-on bit sends packet every poll
// - Otherwise packet only after enabled event
// - Enable zero blocks, one allows event
// - Bit 28 gates OTP write done
// - Bits 26..24 gate low-power idle events
// - Bit 23 gates MAC reset timeout
// - Bit 22 gates receive FIFO overflow
// - Bit 21 gates transmit error
// - Bit 20 gates bus status change
// - Bits 19, 18 gate path disables
// - Bit 17 gates transceiver interrupt
// - Bit 16 gates data port event
// - Bit 15 gates MAC error
// - Bits 14, 13 gate FIFO under/overrun
// - Bit 12 gates bulk-in frame pending
// - Bits 11..0 gate twelve pin events
// - Bus status flag from change bits
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module usb_interrupt_endpoint_event_gate
  import irq_ep_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  event_t           events,
  input  wire logic [15:0] bus_change_set,
  input  wire logic [15:0] bus_state,
  input  wire logic        poll,
  output logic             packet_send,
  output logic [31:0]      packet_status,
  output logic             irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0] enables;
  logic [31:0] latched_src;
  logic [15:0] bus_changes;
  logic        pending;
  logic [1:0]  evt_status;
  logic [1:0]  evt_mask;
  logic [31:0] rdata_mux;
  logic [31:0] source_word;
  logic [31:0] byte_mask;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire         wr_en      = psel & penable & pwrite;
  wire         sel_enab   = paddr == EP_ENABLES_OFFSET;
  wire         sel_stat   = paddr == EVT_STATUS_OFFSET;
  wire         sel_mask   = paddr == EVT_MASK_OFFSET;
  wire         sel_src    = paddr == SOURCE_OFFSET;
  wire         sel_bus    = paddr == BUS_STATUS_OFFSET;
  wire         mapped     = sel_enab | sel_stat | sel_mask | sel_src
                            | sel_bus;

  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                      {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;

  // ---------------------------------------------------------------
  // Event gating
  // ---------------------------------------------------------------
  // Bus change bits
  wire bus_flag = |bus_changes;

  event_map u_map (
    .events      (events),
    .bus_change  (bus_flag),
    .source_word (source_word)
  );

  // Per-source gating
  // ..each source bit meets its own enable bit
  wire [31:0] gated     = source_word & enables & EP_ENABLES_WMASK
                          & ~(32'h1 << ALWAYS_ON_BIT);
  wire        any_event = |gated;
  wire        always_on = enables[ALWAYS_ON_BIT];

  wire        send_now  = poll & (always_on | pending | any_event);

  // ---------------------------------------------------------------
  // Enable register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enables <= EP_ENABLES_RESET;
    end else if (wr_en && sel_enab) begin
      enables <= (enables & ~(byte_mask & EP_ENABLES_WMASK))
                 | (pwdata & byte_mask & EP_ENABLES_WMASK);
    end
  end

  // ---------------------------------------------------------------
  // Bus change bits, write one to clear, set wins
  // ---------------------------------------------------------------
  wire [15:0] bus_clr = (wr_en && sel_bus) ?
                        (pwdata[15:0] & byte_mask[15:0]) : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_changes <= BUS_STATUS_RESET[15:0];
    end else begin
      bus_changes <= (bus_changes & ~bus_clr) | bus_change_set;
    end
  end

  // ---------------------------------------------------------------
  // Pending request and packet
  // ---------------------------------------------------------------
  // Hold until next poll
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (send_now) begin
      pending <= 1'b0;
    end else if (any_event) begin
      pending <= 1'b1;
    end
  end

  // Sources stay latched so short pulses still reach the host
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latched_src <= 32'h0000_0000;
    end else if (send_now) begin
      latched_src <= source_word;
    end else begin
      latched_src <= latched_src | source_word;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      packet_send   <= 1'b0;
      packet_status <= 32'h0000_0000;
    end else begin
      packet_send   <= send_now;
      if (send_now) begin
        packet_status <= latched_src | source_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software interrupt, write one to clear, set wins
  // ---------------------------------------------------------------
  wire [1:0] evt_set = {any_event, send_now};
  wire [1:0] evt_clr = (wr_en && sel_stat && pstrb[0]) ?
                       pwdata[1:0] : 2'b00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_status <= 2'b00;
      evt_mask   <= 2'b00;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      if (wr_en && sel_mask && pstrb[0]) begin
        evt_mask <= pwdata[1:0];
      end
    end
  end

  assign irq = |(evt_status & evt_mask);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  assign rdata_mux = sel_enab ? (enables & EP_ENABLES_WMASK) :
                     sel_stat ? {30'h0, evt_status} :
                     sel_mask ? {30'h0, evt_mask} :
                     sel_src  ? latched_src :
                     sel_bus  ? {bus_state, bus_changes} :
                     32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_mux;
    end
  end

endmodule : usb_interrupt_endpoint_event_gate

// ==== dv/irq_ep_assertions.sv ====
`timescale 1ns/100ps
module irq_ep_assertions
  import irq_ep_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input event_t           events,
  input wire logic [15:0] bus_change_set,
  input wire logic        poll,
  input wire logic        packet_send,
  input wire logic [31:0] packet_status
);
  // ------
  // Shadow
  // ------
  logic [31:0] en;
  logic [15:0] ch;
  logic        pend;
  wire         wr = psel && penable && pwrite;
  wire  [15:0] clr = (wr && paddr == BUS_STATUS_OFFSET) ? pwdata[15:0] : '0;
  wire  [31:0] src = {3'h0, events[26], 1'b0, events[25:20], |ch,
                      events[19:0]};
  wire  [31:0] gated = src & en;
  wire         bus_now = en[20] && |bus_change_set;
  // Whole words only; the bench never narrows the byte lanes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en   <= '0;
      ch   <= '0;
      pend <= 1'b0;
    end else begin
      if (wr && paddr == EP_ENABLES_OFFSET)
        en <= pwdata & EP_ENABLES_WMASK;
      ch   <= (ch & ~clr) | bus_change_set;
      pend <= (pend && !packet_send) || (|gated) || bus_now;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_on_a: assert property (poll && en[31] |=> packet_send)
    else $error("no packet while always on");
  send_cause_a: assert property (packet_send |-> $past(poll))
    else $error("packet without poll");
  blocked_event_a: assert property (poll && !en[31] && !pend &&
    gated == '0 && !bus_now |=> !packet_send)
    else $error("packet with nothing enabled");
  gated_send_a: assert property (poll && gated != '0 |=> packet_send)
    else $error("enabled event not sent");
  status_hold_a: assert property (!packet_send |-> $stable(packet_status))
    else $error("status moved between packets");
  bus_flag_a: assert property (poll && |ch |=>
    !packet_send || packet_status[20])
    else $error("bus flag missing");
  enables_read_a: assert property (psel && penable && !pwrite &&
    paddr == EP_ENABLES_OFFSET |-> prdata == en)
    else $error("enables readback wrong");
  pin_gate_a: assert property (poll && |(events.pins & en[11:0])
    |=> packet_send)
    else $error("pin event not sent");
endmodule : irq_ep_assertions

bind usb_interrupt_endpoint_event_gate irq_ep_assertions irq_ep_assertions_i (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .events,
  .bus_change_set, .poll, .packet_send, .packet_status);

// ==== dv/poll_host_model.sv ====
`timescale 1ns/100ps
module poll_host_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] gap,
  output logic            poll
);
  // ----------
  // Host polls
  // ----------
  logic [7:0] cnt;
  // Gap sets prompt or slow service of the endpoint
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt  <= 8'h00;
      poll <= 1'b0;
    end else begin
      poll <= (cnt == 8'h00);
      cnt  <= (cnt == 8'h00) ? gap : cnt - 8'h01;
    end
  end
endmodule : poll_host_model

// ==== dv/usb_interrupt_endpoint_event_gate_tb_top.sv ====
`timescale 1ns/100ps
module usb_interrupt_endpoint_event_gate_tb_top;
  import irq_ep_pkg::*;
  // -------
  // Harness
  // -------
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        poll, packet_send, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, packet_status, rd, rnd, s;
  logic [15:0] bus_change_set;
  logic [7:0]  gap;
  event_t      events;
  int          mismatches, n_tests, pkts;

  usb_interrupt_endpoint_event_gate usb_interrupt_endpoint_event_gate_i (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .pready, .prdata, .pslverr, .events, .bus_change_set,
    .bus_state(16'h5A5A), .poll, .packet_send, .packet_status, .irq);
  poll_host_model poll_host_model_i (.clk, .rst, .gap, .poll);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (packet_send === 1'b1) pkts <= pkts + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic want(input logic [31:0] en, input logic [31:0] v);
    return en[31] || |(v & en & 32'h97FF_FFFF);
  endfunction : want

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Pulse one source, then judge the packet count at the next poll
  task automatic run(input logic [31:0] en, input logic [31:0] v);
    int p0;
    apb(1'b1, EP_ENABLES_OFFSET, en);
    // Start just after a poll so the pulse never meets one
    while (poll !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    p0 = pkts;
    events <= event_t'({v[28], v[26:21], v[19:0]});
    bus_change_set <= v[20] ? (rnd[15:0] | 16'h0001) : 16'h0000;
    @(posedge clk);
    events <= '0;
    bus_change_set <= '0;
    @(posedge clk);
    while (poll !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(32'(pkts - p0), {31'h0, want(en, v)}); // gate decides packet
    if (want(en, v)) chk(packet_status & v, v); // source reported
    apb(1'b1, BUS_STATUS_OFFSET, 32'h0000_FFFF);
  endtask : run
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '1;
    {psel, penable, paddr, pwdata, events, bus_change_set} = '0;
    {gap, mismatches, n_tests, pkts} = '0;
    gap = 8'h05;
    rnd = 32'hB8DC4681;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, EP_ENABLES_OFFSET, '0);
    chk(rd, 32'h0); // enables reset to zero
    apb(1'b1, EP_ENABLES_OFFSET, '1);
    apb(1'b0, EP_ENABLES_OFFSET, '0);
    chk(rd, 32'h97FF_FFFF); // reserved bits stay zero
    apb(1'b0, 12'h0FC, '0);
    chk({31'h0, err}, 32'h1); // unmapped read refused
    chk(rd, 32'h0); // unmapped read gives zero
    run(32'h8000_0000, '0); // packet with no event
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr(rnd);
      s = (32'h1 << (rnd[7:0] % 29)) & 32'h17FF_FFFF;
      gap <= 8'h03 + rnd[12:8];
      rnd = lfsr(rnd);
      run(rnd, s); // each source gated alone
    end
    apb(1'b1, EP_ENABLES_OFFSET, '0);
    apb(1'b0, BUS_STATUS_OFFSET, '0);
    chk(rd, 32'h5A5A_0000); // state mirror, changes cleared
    // Let a leftover pending request drain before the flag checks
    while (poll !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    apb(1'b1, EVT_MASK_OFFSET, '0);
    chk({31'h0, irq}, 32'h0); // masked sent flag stays quiet
    apb(1'b1, EVT_MASK_OFFSET, 32'h1);
    chk({31'h0, irq}, 32'h1); // sent flag raises line
    apb(1'b1, EVT_STATUS_OFFSET, 32'h3);
    chk({31'h0, irq}, 32'h0); // write one clears flag
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule : usb_interrupt_endpoint_event_gate_tb_top
